// File: src/sbca_bus_access.sv
// Purpose: Idle detection, collision abort and priority classes on a wired-OR bus
// Assumes: Transmit clock and feedback arrive as pins, far slower than clk_i
// Notes: Frame bits come one at a time from the transmit FIFO side
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "sbca_defs.svh"
module sbca_bus_access #(
    parameter int CNT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic tx_clk_i,
    input wire logic collision_feedback_in_i,
    input wire logic tx_valid_i,
    input wire logic tx_bit_i,
    input wire logic tx_last_i,
    input wire logic frame_start_avail_i,
    output logic tx_take_o,
    output logic rewind_o,
    output logic txd_o,
    output logic txd_oe_n_o,
    output logic rts_n_o
);
    import sbca_pkg::*;
    localparam logic [CNT_W-1:0] THR_HI = CNT_W'(`SBCA_IDLE_ONES);
    localparam logic [CNT_W-1:0] THR_LO = CNT_W'(`SBCA_LOWPRIO_ONES);
    initial begin
        if (CNT_W < 4 || CNT_W > 8) begin
            $error("sbca_bus_access: CNT_W must be 4 to 8");
        end
    end

    sbca_reg_if rif ();
    logic [1:0] pin_q;
    logic tclk;
    logic fb;
    logic tclk_d;
    logic [1:0] warm;
    logic rise;
    logic fall;
    logic bus_on;
    logic drv;
    logic chk;
    sbca_state_t state;
    logic [CNT_W-1:0] ones;
    logic low_prio;
    logic [CNT_W-1:0] thr;
    logic idle;
    logic line_bit;
    logic sent_last;
    logic have_bit;
    logic sent_ok;
    logic collide;
    logic frame_end;
    logic start;
    logic all_sent;
    logic ev_rep;
    logic ev_sent;

    sbca_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({tx_clk_i, collision_feedback_in_i}),
        .q_o(pin_q)
    );

    sbca_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .irq_o(irq_o),
        .rif(rif.regs)
    );

    assign tclk = pin_q[1];
    assign fb = pin_q[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tclk_d <= 1'b1;
        end else begin
            tclk_d <= tclk;
        end
    end
    // Synchroniser and delay stage hold reset ones; ignore edges until both carry the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warm <= 2'h0;
        end else if (warm != 2'h3) begin
            warm <= warm + 2'h1;
        end
    end
    assign rise = tclk & ~tclk_d & (warm == 2'h3);
    assign fall = ~tclk & tclk_d & (warm == 2'h3);

    // Edge choice per timing mode; a non-bus code leaves the check off
    assign bus_on = (rif.bus_coding_select == `SBCA_CODE_MODE1)
        || (rif.bus_coding_select == `SBCA_CODE_MODE2);
    assign drv = (rif.bus_coding_select == `SBCA_CODE_MODE2) ? fall : rise;
    assign chk = fall;

    assign thr = low_prio ? THR_LO : THR_HI;
    assign idle = (ones >= thr) || !bus_on;
    // Mode 2 checks the old bit before the same edge drives the next one
    assign collide = (state == SBCA_ST_SEND) && chk && bus_on && have_bit
        && (fb != line_bit);
    assign frame_end = (state == SBCA_ST_SEND) && drv && !collide && sent_last
        && have_bit;
    assign start = (state == SBCA_ST_MON) && drv && tx_valid_i && idle;

    // Any zero restarts the count, so a frame in flight keeps the bus busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ones <= '0;
        end else if (chk && !fb) begin
            ones <= '0;
        end else if (chk && ones < THR_LO) begin
            ones <= ones + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_prio <= 1'b0;
        end else if (frame_end && bus_on) begin
            low_prio <= 1'b1;
        end else if (ones == THR_LO) begin
            low_prio <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SBCA_ST_MON;
            line_bit <= 1'b1;
            sent_last <= 1'b0;
            have_bit <= 1'b0;
        end else if (collide) begin
            state <= SBCA_ST_MON;
            line_bit <= 1'b1;
            have_bit <= 1'b0;
        end else if (frame_end) begin
            state <= SBCA_ST_MON;
            line_bit <= 1'b1;
            have_bit <= 1'b0;
        end else if (start) begin
            state <= SBCA_ST_SEND;
            line_bit <= tx_bit_i;
            sent_last <= tx_last_i;
            have_bit <= 1'b1;
        end else if (state == SBCA_ST_SEND && drv) begin
            // An empty source between bits leaves the line at one
            line_bit <= tx_valid_i ? tx_bit_i : 1'b1;
            sent_last <= tx_valid_i & tx_last_i;
            have_bit <= tx_valid_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_take_o <= 1'b0;
        end else begin
            tx_take_o <= (start || (state == SBCA_ST_SEND && drv && !collide
                && !frame_end)) && tx_valid_i;
        end
    end

    // Restart only if the frame head is still queued, else ask software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rewind_o <= 1'b0;
            ev_rep <= 1'b0;
        end else begin
            rewind_o <= collide && frame_start_avail_i;
            ev_rep <= collide && !frame_start_avail_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            all_sent <= 1'b1;
            ev_sent <= 1'b0;
        end else begin
            ev_sent <= frame_end;
            if (frame_end) begin
                all_sent <= 1'b1;
            end else if (start) begin
                all_sent <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sent_ok <= 1'b0;
        end else if (collide) begin
            sent_ok <= 1'b0;
        end else if (chk && state == SBCA_ST_SEND) begin
            sent_ok <= have_bit;
        end else if (drv) begin
            sent_ok <= 1'b0;
        end
    end

    // Lags data by one bit in mode 1 and two bits in mode 2: the bit only counts once it survived its check
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rts_n_o <= 1'b1;
        end else if (drv) begin
            rts_n_o <= ~(rif.rts_en & sent_ok);
        end
    end

    // Open-drain pulls low for a zero and floats for a one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd_o <= 1'b1;
            txd_oe_n_o <= 1'b0;
        end else if (rif.od_en) begin
            txd_o <= 1'b0;
            txd_oe_n_o <= line_bit;
        end else begin
            txd_o <= line_bit;
            txd_oe_n_o <= 1'b0;
        end
    end

    assign rif.status = {ones[3:0], all_sent, idle, low_prio, state == SBCA_ST_SEND};
    assign rif.events[`SBCA_EV_COLLIDE] = collide;
    assign rif.events[`SBCA_EV_REPEAT] = ev_rep;
    assign rif.events[`SBCA_EV_SENT] = ev_sent;
    assign rif.events[`SBCA_EV_RESTART] = rewind_o;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_collide;
        state == SBCA_ST_SEND && chk && bus_on && have_bit && fb != line_bit;
    endsequence
    sequence s_done;
        frame_end && bus_on;
    endsequence

    a_abort_sends_one: assert property (s_collide |=> line_bit && state == SBCA_ST_MON)
        else $error("collision did not abort to idle ones");
    a_monitor_holds_one: assert property (state == SBCA_ST_MON |-> line_bit)
        else $error("line not at one while monitoring");
    a_start_after_idle: assert property (state == SBCA_ST_MON ##1 state == SBCA_ST_SEND
        |-> $past(ones) >= $past(thr) || !$past(bus_on))
        else $error("frame started before idle count");
    a_zero_clears_count: assert property (chk && !fb |=> ones == '0)
        else $error("ones count not cleared by zero");
    a_count_saturates: assert property (ones <= THR_LO)
        else $error("ones count beyond saturation");
    a_prio_drops: assert property (s_done |=> low_prio ##1 (low_prio || ones == THR_LO))
        else $error("priority class not lowered after frame");
    a_prio_restore: assert property (low_prio && ones == THR_LO && !frame_end
        |=> !low_prio)
        else $error("high class not restored after ten ones");
    a_repeat_raised: assert property (s_collide ##0 !frame_start_avail_i
        |=> ev_rep && !rewind_o)
        else $error("transmit repeat not raised");
    a_rts_marks_ok: assert property (drv && sent_ok && rif.rts_en |=> !rts_n_o)
        else $error("rts not active for clean bit");
    a_od_pin: assert property (rif.od_en |=> !txd_o && txd_oe_n_o == $past(line_bit))
        else $error("open-drain pin drive wrong");
endmodule : sbca_bus_access

// File: common/sbca_defs.svh
// Purpose: Register map, field positions and thresholds of the bus access block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes: Included by the design files and by the testbench
`ifndef SBCA_DEFS_SVH
`define SBCA_DEFS_SVH
`define SBCA_ADR_CTRL 8'h00
`define SBCA_ADR_STATUS 8'h04
`define SBCA_ADR_IRQ_STAT 8'h08
`define SBCA_ADR_IRQ_CLR 8'h0c
`define SBCA_ADR_IRQ_EN 8'h10
`define SBCA_CTRL_CODE_LSB 0
`define SBCA_CTRL_OD_BIT 3
`define SBCA_CTRL_RTS_BIT 4
`define SBCA_CTRL_RST 5'h00
`define SBCA_IRQ_RST 4'h0
`define SBCA_EV_COLLIDE 0
`define SBCA_EV_REPEAT 1
`define SBCA_EV_SENT 2
`define SBCA_EV_RESTART 3
`define SBCA_CODE_MODE1 3'h1
`define SBCA_CODE_MODE2 3'h3
`define SBCA_IDLE_ONES 8
`define SBCA_LOWPRIO_ONES 10
`endif

// File: common/sbca_pkg.sv
// Purpose: Shared types of the bus access block
// Assumes: Constants live in sbca_defs.svh
// Notes: None
package sbca_pkg;
    typedef enum logic [0:0] {
        SBCA_ST_MON = 1'b0,
        SBCA_ST_SEND = 1'b1
    } sbca_state_t;
    typedef logic [2:0] sbca_code_t;
    typedef logic [3:0] sbca_ev_t;
endpackage : sbca_pkg

// File: common/sbca_reg_if.sv
// Purpose: Control, status and events between core and register file
// Assumes: Single clock domain
// Notes: Events are one-cycle pulses
`timescale 1ns/100ps
interface sbca_reg_if;
    import sbca_pkg::*;
    sbca_code_t bus_coding_select;
    logic od_en;
    logic rts_en;
    logic [7:0] status;
    sbca_ev_t events;
    modport regs (
        output bus_coding_select,
        output od_en,
        output rts_en,
        input status,
        input events
    );
    modport core (
        input bus_coding_select,
        input od_en,
        input rts_en,
        output status,
        output events
    );
endinterface : sbca_reg_if

// File: src/sbca_sync.sv
// Purpose: Two-flop synchronisers for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: Only the second stage is visible outside
`timescale 1ns/100ps
module sbca_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    initial begin
        if (WIDTH < 1) begin
            $error("sbca_sync: WIDTH must be at least 1");
        end
    end
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta[g] <= 1'b1;
                    q_o[g] <= 1'b1;
                end else begin
                    meta[g] <= d_i[g];
                    q_o[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule : sbca_sync

// File: src/sbca_regs.sv
// Purpose: Classic Wishbone register file with sticky interrupt status
// Assumes: 32-bit data, byte addresses, one word per register
// Notes: Unmapped reads return zero and are still acknowledged
`timescale 1ns/100ps
`include "sbca_defs.svh"
module sbca_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    sbca_reg_if.regs rif
);
    import sbca_pkg::*;
    logic [4:0] ctrl;
    sbca_ev_t irq_stat;
    sbca_ev_t irq_en;
    logic acc;
    logic wr;
    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign rif.bus_coding_select = ctrl[`SBCA_CTRL_CODE_LSB +: 3];
    assign rif.od_en = ctrl[`SBCA_CTRL_OD_BIT];
    assign rif.rts_en = ctrl[`SBCA_CTRL_RTS_BIT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `SBCA_CTRL_RST;
            irq_en <= `SBCA_IRQ_RST;
        end else if (wr && wb_adr_i == `SBCA_ADR_CTRL) begin
            ctrl <= wb_dat_i[4:0];
        end else if (wr && wb_adr_i == `SBCA_ADR_IRQ_EN) begin
            irq_en <= wb_dat_i[3:0];
        end
    end
    // A new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= `SBCA_IRQ_RST;
        end else if (wr && wb_adr_i == `SBCA_ADR_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~wb_dat_i[3:0]) | rif.events;
        end else begin
            irq_stat <= irq_stat | rif.events;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_en);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (acc && !wb_we_i) begin
            if (wb_adr_i == `SBCA_ADR_CTRL) begin
                wb_dat_o <= {27'h0, ctrl};
            end else if (wb_adr_i == `SBCA_ADR_STATUS) begin
                wb_dat_o <= {24'h0, rif.status};
            end else if (wb_adr_i == `SBCA_ADR_IRQ_STAT) begin
                wb_dat_o <= {28'h0, irq_stat};
            end else if (wb_adr_i == `SBCA_ADR_IRQ_EN) begin
                wb_dat_o <= {28'h0, irq_en};
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end
endmodule : sbca_regs

// File: verification/sbca_bus_partner.sv
// Purpose: Other stations and pull-up on the shared wired-OR line
// Assumes: Transmit clock runs free at 5 MHz, 20 clk_i cycles a bit
// Notes: A jam request makes the other station send zeros from the next rising edge
`timescale 1ns/100ps
module sbca_bus_partner (
    input wire logic txd_i,
    input wire logic txd_oe_n_i,
    input wire logic jam_i,
    output logic tx_clk_o,
    output logic fb_o
);
    logic other_hi;
    initial begin
        tx_clk_o = 1'b0;
        other_hi = 1'b1;
        forever #100 tx_clk_o = ~tx_clk_o;
    end
    // NRZ bit changes with the rising edge only
    always @(posedge tx_clk_o) begin
        other_hi <= ~jam_i;
    end
    // Pull-up unless any station pulls low, so a zero dominates
    assign fb_o = ~(~txd_oe_n_i & ~txd_i) & other_hi;
endmodule : sbca_bus_partner

// File: verification/sbca_bus_access_tb_top.sv
// Purpose: Self-checking bench of the bus access block
// Assumes: Partner makes the transmit clock and the wired-OR line
// Notes: Frame bits leave LSB first; waits poll interrupt status since bit timing is slow
`timescale 1ns/100ps
`include "sbca_defs.svh"
module sbca_bus_access_tb_top;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, tx_clk_i, fb;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic tx_valid_i, tx_bit_i, tx_last_i, avail, tx_take_o, rewind_o, txd_o;
    logic txd_oe_n_o, rts_n_o, jam, fr_on, fr_load, od, rts_chk, lvl, tk_d, bit_d;
    logic [11:0] fr_bits;
    int idx, run, exp_run, rew_cnt, fail_count, total_checks, cyc_cnt;

    sbca_bus_access #(.CNT_W(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .tx_clk_i(tx_clk_i),
        .collision_feedback_in_i(fb), .tx_valid_i(tx_valid_i), .tx_bit_i(tx_bit_i),
        .tx_last_i(tx_last_i), .frame_start_avail_i(avail), .tx_take_o(tx_take_o),
        .rewind_o(rewind_o), .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o), .rts_n_o(rts_n_o));
    sbca_bus_partner u_bus (.txd_i(txd_o), .txd_oe_n_i(txd_oe_n_o), .jam_i(jam),
        .tx_clk_o(tx_clk_i), .fb_o(fb));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task final_report;
        $display("Checks made %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task check_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit

    task check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word

    task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) fail_count++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_xfer

    task rdc(input string nm, input logic [7:0] adr, input logic [31:0] e);
        wb_xfer(1'b0, adr, 32'h0);
        check_word(nm, e, rd);
    endtask : rdc

    task wait_irq(input int b);
        for (int k = 0; k < 400; k++) begin
            wb_xfer(1'b0, `SBCA_ADR_IRQ_STAT, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        check_bit("irq_stat event", 1'b1, rd[b]);
    endtask : wait_irq

    task start_frame(input logic [11:0] b, input int er, input logic el);
        fr_bits <= b;
        exp_run <= er;
        lvl <= el;
        fr_on <= 1'b1;
        fr_load <= 1'b1;
        @(posedge clk_i);
        fr_load <= 1'b0;
    endtask : start_frame

    task jam_at_bit4;
        for (int k = 0; k < 2000 && idx != 4; k++) @(posedge clk_i);
        jam <= 1'b1;
    endtask : jam_at_bit4

    // Frame source and per-bit pin monitor
    always @(posedge clk_i) begin : src
        int n;
        n = (rewind_o === 1'b1 || fr_load) ? 0 : idx + (tx_take_o === 1'b1);
        // Pins follow the taken bit one cycle after the take pulse
        if (tk_d) begin
            check_bit("txd_o bit", od ? 1'b0 : bit_d, txd_o);
            check_bit("txd_oe_n_o bit", od ? bit_d : 1'b0, txd_oe_n_o);
        end
        tk_d <= (tx_take_o === 1'b1);
        bit_d <= tx_bit_i;
        if (tx_take_o === 1'b1) begin
            if (idx == 0) check_bit("start edge", lvl, tx_clk_i);
            if (idx == 0) check_bit("ones before start", 1'b1, run >= exp_run);
            if (rts_chk && idx == 0) check_bit("rts_n_o first", 1'b1, rts_n_o);
            if (rts_chk && idx == 2) check_bit("rts_n_o lag", 1'b0, rts_n_o);
        end
        if (rewind_o === 1'b1) rew_cnt++;
        idx <= n;
        tx_valid_i <= fr_on && n < 12;
        tx_bit_i <= fr_bits[n % 12];
        tx_last_i <= n == 11;
    end

    always @(negedge tx_clk_i) run <= (fb === 1'b1) ? run + 1 : 0;

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            fail_count++;
            final_report;
        end
    end

    task t_reset;
        check_bit("txd_o idle", 1'b1, txd_o);
        check_bit("rts_n_o idle", 1'b1, rts_n_o);
        rdc("ctrl", `SBCA_ADR_CTRL, 32'h0);
        rdc("status", `SBCA_ADR_STATUS, 32'h0c);
        wb_xfer(1'b1, `SBCA_ADR_STATUS, 32'hff);
        rdc("status ro", `SBCA_ADR_STATUS, 32'h0c);
        rdc("unmapped", 8'h20, 32'h0);
        rdc("irq_stat", `SBCA_ADR_IRQ_STAT, 32'h0);
        repeat (240) @(posedge clk_i);
        rdc("status idle", `SBCA_ADR_STATUS, 32'hac);
    endtask : t_reset

    task t_good;
        wb_xfer(1'b1, `SBCA_ADR_CTRL, 32'h11);
        wb_xfer(1'b1, `SBCA_ADR_IRQ_EN, 32'h4);
        rts_chk <= 1'b1;
        start_frame(12'h7e6, 8, 1'b1);
        wait_irq(`SBCA_EV_SENT);
        check_bit("irq_o sent", 1'b1, irq_o);
        wb_xfer(1'b0, `SBCA_ADR_STATUS, 32'h0);
        check_bit("low class", 1'b1, rd[1]);
        check_bit("all sent", 1'b1, rd[3]);
        wb_xfer(1'b1, `SBCA_ADR_IRQ_CLR, 32'hf);
        @(posedge clk_i);
        check_bit("irq_o cleared", 1'b0, irq_o);
        start_frame(12'h7e6, 10, 1'b1);
        wait_irq(`SBCA_EV_SENT);
        repeat (240) @(posedge clk_i);
        rdc("status restored", `SBCA_ADR_STATUS, 32'hac);
        wb_xfer(1'b1, `SBCA_ADR_IRQ_CLR, 32'hf);
        rts_chk <= 1'b0;
    endtask : t_good

    task t_collide;
        wb_xfer(1'b1, `SBCA_ADR_CTRL, 32'h01);
        wb_xfer(1'b1, `SBCA_ADR_IRQ_EN, 32'h1);
        avail <= 1'b1;
        start_frame(12'hffe, 8, 1'b1);
        jam_at_bit4;
        wait_irq(`SBCA_EV_COLLIDE);
        check_bit("irq_o collide", 1'b1, irq_o);
        check_bit("txd_o abort", 1'b1, txd_o);
        check_bit("line winner", 1'b0, fb);
        check_bit("rewind", 1'b1, rew_cnt == 1);
        wb_xfer(1'b1, `SBCA_ADR_IRQ_EN, 32'h0);
        @(posedge clk_i);
        check_bit("irq_o masked", 1'b0, irq_o);
        jam <= 1'b0;
        wait_irq(`SBCA_EV_RESTART);
        wait_irq(`SBCA_EV_SENT);
        wb_xfer(1'b1, `SBCA_ADR_IRQ_CLR, 32'hf);
        rdc("irq_stat clr", `SBCA_ADR_IRQ_STAT, 32'h0);
        // Head already gone: no rewind, software must repeat
        avail <= 1'b0;
        start_frame(12'hffe, 10, 1'b1);
        jam_at_bit4;
        wait_irq(`SBCA_EV_REPEAT);
        check_bit("no rewind", 1'b1, rew_cnt == 1);
        fr_on <= 1'b0;
        jam <= 1'b0;
        wb_xfer(1'b1, `SBCA_ADR_IRQ_CLR, 32'hf);
    endtask : t_collide

    task t_mode2;
        wb_xfer(1'b1, `SBCA_ADR_CTRL, 32'h0b);
        od <= 1'b1;
        start_frame(12'h7e6, 0, 1'b0);
        wait_irq(`SBCA_EV_SENT);
        od <= 1'b0;
    endtask : t_mode2

    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {tx_valid_i, tx_bit_i, tx_last_i, jam, fr_on, fr_load, od, rts_chk, tk_d, bit_d} = '0;
        avail = 1'b1;
        lvl = 1'b1;
        fr_bits = 12'h0;
        {idx, run, exp_run, rew_cnt, fail_count, total_checks, cyc_cnt} = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_good;
        t_collide;
        t_mode2;
        final_report;
    end
endmodule : sbca_bus_access_tb_top
